/* testbench/dps_assertions.sv */
// Protocol checks on the pins between the controller and device ends.
`timescale 1ns/100ps
module dps_assertions
  import dps_pkg::*;
#(
  parameter int unsigned RESET_HOLD_CYC = 20,
  parameter int unsigned INIT_WAIT_CYC = 40
) (
  input logic clk,
  input logic srst,
  input logic resetN,
  input logic cke,
  input logic csN,
  input logic rasN,
  input logic casN,
  input logic weN,
  input logic odt,
  input logic [BA_W-1:0] ba,
  input logic [ADDR_W-1:0] addr
);
  logic [3:0] cmd;
  logic rstPrev_r;
  logic ckeSeen_r;
  logic [CNT_W-1:0] cnt_r;
  assign cmd = {csN, rasN, casN, weN};
  // The counter restarts at every edge of the reset pin, so it measures both waits.
  always_ff @(posedge clk) begin
    if (srst) begin
      rstPrev_r <= 1'h0;
      ckeSeen_r <= 1'h0;
      cnt_r <= 20'h00000;
    end else begin
      rstPrev_r <= resetN;
      ckeSeen_r <= resetN & (ckeSeen_r | cke);
      cnt_r <= (resetN != rstPrev_r) ? CNT_ONE : cnt_r + {19'h00000, ~&cnt_r};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_mr(logic [BA_W-1:0] b);
    cmd == CMD_MRS && ba == b;
  endsequence
  sequence s_dll;
    s_mr(BA_MR1) ##0 !addr[MR1_DLL_BIT] ##4 s_mr(BA_MR0) ##0 addr[MR0_DLLRST_BIT];
  endsequence
  sequence s_zq;
    cmd == CMD_ZQ && addr[AP_BIT];
  endsequence
  pd_entry_a: assert property ($fell(cke) |-> csN || cmd == CMD_NOP || cmd == CMD_REF)
    else $error("CKE fell with a bad command");
  cke_exit_a: assert property ($rose(cke) |-> csN || cmd == CMD_NOP)
    else $error("CKE rose with a bad command");
  cke_hold_a: assert property ($changed(cke) |=> $stable(cke) [*3])
    else $error("CKE pulse too short");
  rst_hold_a: assert property ($rose(resetN) |-> cnt_r >= RESET_HOLD_CYC)
    else $error("Reset pin released too early");
  cke_lead_a: assert property ($rose(resetN) |-> !cke && !$past(cke) && !$past(cke, 3))
    else $error("CKE not low before reset release");
  first_cke_a: assert property ($rose(cke) && !ckeSeen_r |->
    cnt_r >= INIT_WAIT_CYC && $past(cmd) == CMD_NOP)
    else $error("First CKE rise too early or without NOP");
  xpr_wait_a: assert property (s_mr(BA_MR2) |-> $past(cke, 100))
    else $error("First mode set too soon after CKE");
  mrs_order_a: assert property (s_mr(BA_MR2) |->
    ##4 s_mr(BA_MR3) ##4 s_dll ##12 s_zq)
    else $error("Mode set order or ZQ long wrong");
  odt_init_a: assert property (!resetN || !ckeSeen_r || cmd == CMD_MRS || cmd == CMD_ZQ
    |-> !odt)
    else $error("ODT not held low during start-up");
endmodule

/* testbench/testbench.sv */
// Testbench joining the controller and device ends over the pin bundle.
`timescale 1ns/100ps
module testbench;
  import dps_pkg::*;
  localparam int unsigned RH = 20;
  localparam int unsigned IW = 40;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] devState;
  logic [BANKS-1:0] bankOpen;
  logic idle;
  logic odtOn;
  logic selfRefreshing;
  logic wrValid;
  logic [BA_W-1:0] wrBank;
  logic [DQ_W-1:0] wrData;
  logic [DM_W-1:0] wrLaneEn;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic er;
  logic [31:0] wrSeen;
  logic ckeQ;
  time wrT;
  time upT;
  always #2 clk = ~clk;
  dps_if dram();
  dps_ctrl #(.RESET_HOLD_CYC(RH), .INIT_WAIT_CYC(IW)) u_dps_ctrl (.clk(clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dram(dram));
  dps_dev u_dps_dev (.clk(clk), .srst(srst), .dram(dram), .devState(devState),
    .bankOpen(bankOpen), .idle(idle), .odtOn(odtOn), .selfRefreshing(selfRefreshing),
    .wrValid(wrValid), .wrBank(wrBank), .wrData(wrData), .wrLaneEn(wrLaneEn));
  dps_assertions #(.RESET_HOLD_CYC(RH), .INIT_WAIT_CYC(IW)) u_dps_assertions (.clk(clk),
    .srst(srst), .resetN(dram.resetN), .cke(dram.cke), .csN(dram.csN), .rasN(dram.rasN),
    .casN(dram.casN), .weN(dram.weN), .odt(dram.odt), .ba(dram.ba), .addr(dram.addr));
  // Write beats and CKE rises are caught here, since they pass while a task polls.
  always @(posedge clk) begin
    ckeQ <= dram.cke;
    if (dram.cke === 1'h1 && ckeQ === 1'h0) begin
      upT <= $time;
    end
    if (wrValid === 1'h1) begin
      wrSeen <= {11'h000, wrBank, wrLaneEn, wrData};
      wrT <= $time;
    end
  end
  task automatic give_verdict;
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    n_errors++;
    give_verdict();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    if (i == 16) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Polling the pending flag keeps ops apart by more than the CKE hold time.
  task automatic op(input logic [3:0] o, input logic [2:0] b, input logic [13:0] a);
    int i;
    apb(1'h1, OFF_CMD, {2'h0, a, 9'h000, b, o});
    for (i = 0; i < 400; i++) begin
      apb(1'h0, OFF_STATUS, 32'h00000000);
      if (rd[ST_PEND_BIT] === 1'h0) break;
    end
    if (i == 400) hang();
    repeat (8) @(negedge clk);
  endtask
  task automatic t_init;
    int i;
    chk(32'(devState), 32'h00000000);
    apb(1'h1, OFF_MR01, 32'h00050010);
    apb(1'h1, OFF_MR23, 32'h00000008);
    apb(1'h1, OFF_CTRL, 32'h00000003);
    repeat (30) @(negedge clk);
    chk(32'(odtOn), 32'h00000000);
    for (i = 0; i < 400; i++) begin
      apb(1'h0, OFF_STATUS, 32'h00000000);
      if (rd[ST_DONE_BIT] === 1'h1) break;
    end
    if (i == 400) hang();
    chk(rd & 32'h000000FF, 32'h000000D9);
    @(negedge clk);
    chk(32'(devState), 32'h00000002);
    chk(32'(idle), 32'h00000001);
  endtask
  task automatic t_write;
    op(OP_ACT, 3'h1, 14'h0000);
    apb(1'h1, OFF_WDATA, 32'h0002A5C3);
    op(OP_WR, 3'h1, 14'h0000);
    chk(wrSeen, 32'h0005A5C3);
    chk(32'(bankOpen), 32'h00000002);
    chk(32'(idle), 32'h00000000);
  endtask
  task automatic t_pd;
    op(OP_PDE, 3'h0, 14'h0000);
    chk(32'(devState), 32'h00000003);
    chk(32'(selfRefreshing), 32'h00000000);
    op(OP_ACT, 3'h3, 14'h0000);
    chk(32'(bankOpen), 32'h00000002);
    chk(32'(devState), 32'h00000003);
    op(OP_PDX, 3'h0, 14'h0000);
    chk(32'(devState), 32'h00000002);
    op(OP_PRE, 3'h0, 14'h0400);
    chk(32'(bankOpen), 32'h00000000);
    op(OP_PDE, 3'h0, 14'h0000);
    chk(32'(devState), 32'h00000004);
    chk(32'(selfRefreshing), 32'h00000000);
    op(OP_PDX, 3'h0, 14'h0000);
    chk(32'(devState), 32'h00000002);
  endtask
  task automatic t_sref;
    op(OP_SRE, 3'h0, 14'h0000);
    chk(32'(devState), 32'h00000005);
    chk(32'(selfRefreshing), 32'h00000001);
    chk(32'(odtOn), 32'h00000000);
    op(OP_SRX, 3'h0, 14'h0000);
    chk(32'(devState), 32'h00000002);
    chk(32'(idle), 32'h00000000);
    op(OP_ACT, 3'h2, 14'h0000);
    apb(1'h1, OFF_WDATA, 32'h00001234);
    op(OP_WR, 3'h2, 14'h0000);
    chk(wrSeen, 32'h000B1234);
    chk(32'(wrT - upT >= 2048), 32'h00000001);
  endtask
  task automatic t_bad;
    apb(1'h0, 8'h40, 32'h00000000);
    chk({31'h00000000, er}, 32'h00000001);
    chk(rd, 32'h00000000);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    t_init();
    t_write();
    t_pd();
    t_sref();
    t_bad();
    give_verdict();
  end
endmodule

/* verilog/dps_ctrl.sv */
// DDR3 controller end: power-up initialization, power-state commands and an APB register slave.
//
// Overview of operation
// [RULE_01] Device ignores pins while CKE stays low.
// [RULE_02] Power-down entry and exit only with DES/NOP.
// [RULE_03] Self refresh exit only with DES/NOP.
// [RULE_04] Closed banks give precharge, else active power-down.
// [RULE_05] Self refresh only by REF from idle.
// [RULE_06] No refresh happens during power-down.
// [RULE_07] Hold CKE for minimum pulse count.
// [RULE_08] DES during exit time; reads, ODT after DLL.
// [RULE_09] No write for 512 clocks after exit.
// [RULE_10] Termination off throughout self refresh.
// [RULE_11] Idle means closed, quiet, CKE high, timers done.
// [RULE_12] Masked write lanes are discarded.
// [RULE_13] Hold reset low 200 us at power-up.
// [RULE_14] CKE low 10 ns before reset release.
// [RULE_15] Wait 500 us after reset before CKE.
// [RULE_16] Stable clock and NOP before CKE rises.
// [RULE_17] CKE stays high until initialization ends.
// [RULE_18] Termination off until CKE first high.
// [RULE_19] ODT held low during initialization.
// [RULE_20] Wait reset-CKE-exit time before first mode set.
// [RULE_21] Mode registers in order MR2, MR3, MR1, MR0.
// [RULE_22] Long ZQ calibration, then wait DLL and ZQ.
`timescale 1ns/100ps
module dps_ctrl
  import dps_pkg::*;
#(
  parameter int unsigned RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ,
  parameter int unsigned INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ
) (
  input logic clk,
  input logic srst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [APB_AW-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dps_if.ctrl dram
);
  typedef struct packed {
    dps_ctrl_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] mrStep;
    logic [TMR_W-1:0] ckeHold;
    logic [TMR_W-1:0] xsCnt;
    logic [TMR_W-1:0] xsdllCnt;
    logic [TMR_W-1:0] wrBlkCnt;
    logic initEn;
    logic odtEn;
    logic pending;
    logic [31:0] cmdReg;
    logic [31:0] wdReg;
    logic [31:0] mr01;
    logic [31:0] mr23;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic resetN;
    logic cke;
    logic odt;
    logic [3:0] cmd;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DM_W-1:0] dm;
    logic [DQ_W-1:0] dq;
  } dps_ctrl_regs_t;

  dps_ctrl_regs_t r_r;
  dps_ctrl_regs_t r_nxt;
  logic [3:0] op;
  logic [BA_W-1:0] opBa;
  logic [ADDR_W-1:0] opAddr;
  logic [ADDR_W-1:0] mrVal;
  logic [BA_W-1:0] mrBa;

  assign op = r_r.cmdReg[CMD_OP_LSB +: 4];
  assign opBa = r_r.cmdReg[CMD_BA_LSB +: BA_W];
  assign opAddr = r_r.cmdReg[CMD_ADDR_LSB +: ADDR_W];

  // Mode register order is fixed; the DLL bits are forced so software cannot break the sequence.
  always_comb begin
    unique case (r_r.mrStep)
      2'h0: begin
        mrBa = BA_MR2; // [RULE_21]
        mrVal = r_r.mr23[MR_LO_LSB +: ADDR_W];
      end
      2'h1: begin
        mrBa = BA_MR3;
        mrVal = r_r.mr23[MR_HI_LSB +: ADDR_W];
      end
      2'h2: begin
        mrBa = BA_MR1;
        mrVal = r_r.mr01[MR_HI_LSB +: ADDR_W];
        mrVal[MR1_DLL_BIT] = 1'b0; // [RULE_21]
      end
      2'h3: begin
        mrBa = BA_MR0;
        mrVal = r_r.mr01[MR_LO_LSB +: ADDR_W];
        mrVal[MR0_DLLRST_BIT] = 1'b1; // [RULE_21]
      end
    endcase
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.cmd = CMD_DES;
    r_nxt.pready = 1'b0;
    r_nxt.pslverr = 1'b0;
    r_nxt.cnt = (r_r.cnt != '0) ? r_r.cnt - CNT_ONE : r_r.cnt;
    r_nxt.ckeHold = (r_r.ckeHold != TMR_ZERO) ? r_r.ckeHold - TMR_ONE : r_r.ckeHold;
    r_nxt.xsCnt = (r_r.xsCnt != TMR_ZERO) ? r_r.xsCnt - TMR_ONE : r_r.xsCnt;
    r_nxt.xsdllCnt = (r_r.xsdllCnt != TMR_ZERO) ? r_r.xsdllCnt - TMR_ONE : r_r.xsdllCnt;
    r_nxt.wrBlkCnt = (r_r.wrBlkCnt != TMR_ZERO) ? r_r.wrBlkCnt - TMR_ONE : r_r.wrBlkCnt;
    unique case (r_r.st)
      C_OFF: begin
        if (r_r.initEn) begin
          r_nxt.st = C_RSTHOLD;
          r_nxt.cnt = CNT_W'(RESET_HOLD_CYC - 1); // [RULE_13]
        end
      end
      C_RSTHOLD: begin
        if (r_r.cnt == '0) begin
          r_nxt.st = C_CKELEAD;
          r_nxt.cnt = CNT_W'(CKE_LEAD_CYC - 1); // [RULE_14]
        end
      end
      C_CKELEAD: begin
        if (r_r.cnt == '0) begin
          r_nxt.resetN = 1'b1;
          r_nxt.st = C_WAIT;
          r_nxt.cnt = CNT_W'((INIT_WAIT_CYC > CLK_STABLE_CYC) ? INIT_WAIT_CYC - 1 :
                             CLK_STABLE_CYC - 1); // [RULE_15]
        end
      end
      C_WAIT: begin
        if (r_r.cnt == '0) begin
          r_nxt.st = C_NOP;
          r_nxt.cmd = CMD_NOP; // [RULE_16]
        end
      end
      C_NOP: begin
        // Termination request stays low from the first CKE rise until start-up ends.
        r_nxt.odt = 1'b0; // [RULE_19]
        r_nxt.cke = 1'b1; // [RULE_17]
        r_nxt.st = C_XPR;
        r_nxt.cnt = CNT_W'(TXPR_CYC); // [RULE_20]
      end
      C_XPR: begin
        if (r_r.cnt == '0) begin
          r_nxt.st = C_MRS;
          r_nxt.mrStep = 2'h0;
        end
      end
      C_MRS: begin
        if (r_r.cnt == '0) begin
          r_nxt.cmd = CMD_MRS;
          r_nxt.ba = mrBa;
          r_nxt.addr = mrVal;
          r_nxt.mrStep = r_r.mrStep + 2'h1;
          r_nxt.cnt = CNT_W'((r_r.mrStep == 2'h3) ? TMOD_CYC - 1 : TMRD_CYC - 1);
          r_nxt.st = (r_r.mrStep == 2'h3) ? C_MOD : C_MRS;
        end
      end
      C_MOD: begin
        if (r_r.cnt == '0) begin
          r_nxt.cmd = CMD_ZQ;
          r_nxt.addr = '0;
          r_nxt.addr[AP_BIT] = 1'b1; // [RULE_22]
          r_nxt.st = C_ZQ;
          r_nxt.cnt = CNT_W'(TINIT_CYC - 1); // [RULE_22]
        end
      end
      C_ZQ: begin
        if (r_r.cnt == '0) begin
          r_nxt.st = C_READY;
        end
      end
      C_READY: begin
        // DES fills every cycle of the exit window; after self refresh exit reads wait for DLL, writes for 512 clocks.
        if (r_r.pending && r_r.xsCnt == TMR_ZERO && r_r.ckeHold == TMR_ZERO) begin // [RULE_08]
          r_nxt.ba = opBa;
          r_nxt.addr = opAddr;
          r_nxt.pending = 1'b0;
          unique case (op)
            OP_ACT: r_nxt.cmd = CMD_ACT;
            OP_PRE: r_nxt.cmd = CMD_PRE;
            OP_REF: r_nxt.cmd = CMD_REF;
            OP_RD: begin
              r_nxt.pending = (r_r.xsdllCnt != TMR_ZERO); // [RULE_08]
              r_nxt.cmd = r_nxt.pending ? CMD_DES : CMD_RD;
            end
            OP_WR: begin
              r_nxt.pending = (r_r.wrBlkCnt != TMR_ZERO); // [RULE_09]
              r_nxt.cmd = r_nxt.pending ? CMD_DES : CMD_WR;
              r_nxt.dq = r_r.wdReg[DQ_W-1:0];
              r_nxt.dm = r_r.wdReg[WD_MASK_LSB +: DM_W];
            end
            OP_PDE: begin
              r_nxt.cke = 1'b0; // [RULE_02]
              r_nxt.ckeHold = TMR_W'(TCKE_CYC); // [RULE_07]
              r_nxt.st = C_PD;
            end
            OP_SRE: begin
              r_nxt.cke = 1'b0;
              r_nxt.cmd = CMD_REF;
              r_nxt.odt = 1'b0;
              r_nxt.ckeHold = TMR_W'(TCKE_CYC); // [RULE_07]
              r_nxt.st = C_SREF;
            end
            default: begin
            end
          endcase
        end
        if (r_nxt.st == C_READY) begin
          r_nxt.odt = r_r.odtEn && (r_r.xsdllCnt == TMR_ZERO); // [RULE_08]
        end
      end
      C_PD, C_SREF: begin
        if (r_r.st == C_SREF) begin
          r_nxt.odt = 1'b0;
        end
        if (r_r.pending && r_r.ckeHold == TMR_ZERO) begin
          r_nxt.pending = 1'b0;
          if ((r_r.st == C_PD && op == OP_PDX) || (r_r.st == C_SREF && op == OP_SRX)) begin
            r_nxt.cke = 1'b1; // [RULE_03]
            r_nxt.ckeHold = TMR_W'(TCKE_CYC); // [RULE_07]
            r_nxt.st = C_READY;
            if (r_r.st == C_PD) begin
              r_nxt.xsCnt = TMR_W'(TXP_CYC);
            end else begin
              r_nxt.xsCnt = TMR_W'(TXS_CYC); // [RULE_08]
              r_nxt.xsdllCnt = TMR_W'(TXSDLL_CYC);
              r_nxt.wrBlkCnt = TMR_W'(SR_WR_NCK); // [RULE_09]
            end
          end
        end
      end
      default: r_nxt.st = C_OFF;
    endcase
    if (psel && !penable) begin
      r_nxt.pready = 1'b1;
      r_nxt.prdata = '0;
      unique case (paddr)
        OFF_CTRL: begin
          r_nxt.prdata[CTRL_INIT_BIT] = r_r.initEn;
          r_nxt.prdata[CTRL_ODT_BIT] = r_r.odtEn;
        end
        OFF_CMD: r_nxt.prdata = r_r.cmdReg;
        OFF_WDATA: r_nxt.prdata = r_r.wdReg;
        OFF_MR01: r_nxt.prdata = r_r.mr01;
        OFF_MR23: r_nxt.prdata = r_r.mr23;
        OFF_STATUS: begin
          r_nxt.prdata[3:0] = r_r.st;
          r_nxt.prdata[ST_DONE_BIT] = (r_r.st == C_READY) || (r_r.st == C_PD) ||
                                      (r_r.st == C_SREF);
          r_nxt.prdata[ST_PEND_BIT] = r_r.pending;
          r_nxt.prdata[ST_CKE_BIT] = r_r.cke;
          r_nxt.prdata[ST_RST_BIT] = r_r.resetN;
        end
        default: r_nxt.pslverr = 1'b1;
      endcase
    end
    // A command written while one is still queued is dropped; software polls the pending bit.
    if (psel && penable && r_r.pready && pwrite && !r_r.pslverr) begin
      unique case (paddr)
        OFF_CTRL: begin
          r_nxt.initEn = pwdata[CTRL_INIT_BIT];
          r_nxt.odtEn = pwdata[CTRL_ODT_BIT];
        end
        OFF_CMD: begin
          if (!r_nxt.pending) begin
            r_nxt.cmdReg = pwdata;
            r_nxt.pending = 1'b1;
          end
        end
        OFF_WDATA: r_nxt.wdReg = pwdata;
        OFF_MR01: r_nxt.mr01 = pwdata;
        OFF_MR23: r_nxt.mr23 = pwdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_r <= '0;
      r_r.cmd <= CMD_DES;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = r_r.pslverr;
  assign dram.resetN = r_r.resetN;
  assign dram.cke = r_r.cke;
  assign dram.csN = r_r.cmd[3];
  assign dram.rasN = r_r.cmd[2];
  assign dram.casN = r_r.cmd[1];
  assign dram.weN = r_r.cmd[0];
  assign dram.odt = r_r.odt;
  assign dram.ba = r_r.ba;
  assign dram.addr = r_r.addr;
  assign dram.dm = r_r.dm;
  assign dram.dq = r_r.dq;
endmodule

/* verilog/dps_dev.sv */
// DDR3 device end: power-state tracking, termination gating and masked write capture.
`timescale 1ns/100ps
module dps_dev
  import dps_pkg::*;
(
  input logic clk,
  input logic srst,
  dps_if.dev dram,
  output logic [2:0] devState,
  output logic [BANKS-1:0] bankOpen,
  output logic idle,
  output logic odtOn,
  output logic selfRefreshing,
  output logic wrValid,
  output logic [BA_W-1:0] wrBank,
  output logic [DQ_W-1:0] wrData,
  output logic [DM_W-1:0] wrLaneEn
);
  typedef struct packed {
    dps_dev_state_t st;
    logic ckePrev;
    logic [BANKS-1:0] bankOpen;
    logic [TMR_W-1:0] burstCnt;
    logic [TMR_W-1:0] exitCnt;
    logic odtAllowed;
    logic odtOn;
    logic idle;
    logic srefOn;
    logic wrValid;
    logic [BA_W-1:0] wrBank;
    logic [DQ_W-1:0] wrData;
    logic [DM_W-1:0] wrLaneEn;
  } dps_dev_regs_t;

  dps_dev_regs_t r_r;
  dps_dev_regs_t r_nxt;
  logic [3:0] cmdIn;
  logic quietCmd;

  assign cmdIn = dram.csN ? CMD_DES : {1'b0, dram.rasN, dram.casN, dram.weN};
  assign quietCmd = (cmdIn == CMD_DES) || (cmdIn == CMD_NOP);

  always_comb begin
    r_nxt = r_r;
    r_nxt.ckePrev = dram.cke;
    r_nxt.wrValid = 1'b0;
    r_nxt.burstCnt = (r_r.burstCnt != TMR_ZERO) ? r_r.burstCnt - TMR_ONE : r_r.burstCnt;
    r_nxt.exitCnt = (r_r.exitCnt != TMR_ZERO) ? r_r.exitCnt - TMR_ONE : r_r.exitCnt;
    if (!dram.resetN) begin
      // Termination stays off and all state but the CKE sample is cleared while the reset pin is low.
      r_nxt = '0; // [RULE_18]
      r_nxt.ckePrev = dram.cke;
    end else begin
      unique case (r_r.st)
        D_RESET: begin
          r_nxt.st = D_INIT;
        end
        D_INIT: begin
          if (dram.cke) begin
            r_nxt.st = D_NORM;
            r_nxt.odtAllowed = 1'b1; // [RULE_18]
          end
        end
        D_NORM: begin
          if (r_r.ckePrev && !dram.cke) begin
            // A refresh on the falling edge enters self refresh only from a fully idle state.
            if (cmdIn == CMD_REF && r_r.bankOpen == '0 && r_r.burstCnt == TMR_ZERO &&
                r_r.exitCnt == TMR_ZERO) begin
              r_nxt.st = D_SREF; // [RULE_05]
            end else if (quietCmd) begin
              r_nxt.st = (r_r.bankOpen == '0) ? D_PPD : D_APD; // [RULE_04]
            end
          end else if (dram.cke) begin
            unique case (cmdIn)
              CMD_ACT: r_nxt.bankOpen[dram.ba] = 1'b1;
              CMD_PRE: begin
                if (dram.addr[AP_BIT]) begin
                  r_nxt.bankOpen = '0;
                end else begin
                  r_nxt.bankOpen[dram.ba] = 1'b0;
                end
              end
              CMD_RD, CMD_WR: begin
                r_nxt.burstCnt = TMR_W'(BURST_CYC);
                if (dram.addr[AP_BIT]) begin
                  r_nxt.bankOpen[dram.ba] = 1'b0;
                end
                if (cmdIn == CMD_WR) begin
                  r_nxt.wrValid = 1'b1;
                  r_nxt.wrBank = dram.ba;
                  r_nxt.wrData = dram.dq;
                  r_nxt.wrLaneEn = ~dram.dm; // [RULE_12]
                end
              end
              default: begin
              end
            endcase
          end
        end
        D_APD, D_PPD, D_SREF: begin
          // With CKE low the command and address pins are not looked at, so floating is harmless.
          if (dram.cke) begin // [RULE_01]
            r_nxt.st = D_NORM;
            r_nxt.exitCnt = TMR_W'((r_r.st == D_SREF) ? TXS_CYC : TXP_CYC);
          end
        end
        default: r_nxt.st = D_RESET;
      endcase
    end
    // Internal refresh runs only in self refresh; power-down keeps no refresh going.
    r_nxt.srefOn = (r_nxt.st == D_SREF); // [RULE_06]
    r_nxt.odtOn = dram.odt && r_nxt.odtAllowed && (r_nxt.st != D_SREF); // [RULE_10]
    r_nxt.idle = (r_nxt.st == D_NORM) && (r_nxt.bankOpen == '0) && dram.cke &&
                 (r_nxt.burstCnt == TMR_ZERO) && (r_nxt.exitCnt == TMR_ZERO); // [RULE_11]
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign devState = r_r.st;
  assign bankOpen = r_r.bankOpen;
  assign idle = r_r.idle;
  assign odtOn = r_r.odtOn;
  assign selfRefreshing = r_r.srefOn;
  assign wrValid = r_r.wrValid;
  assign wrBank = r_r.wrBank;
  assign wrData = r_r.wrData;
  assign wrLaneEn = r_r.wrLaneEn;
endmodule

/* verilog/dps_if.sv */
// Pin bundle between the memory controller end and the DDR3 device end.
`timescale 1ns/100ps
interface dps_if;
  import dps_pkg::*;
  logic resetN;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic odt;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DM_W-1:0] dm;
  logic [DQ_W-1:0] dq;
  modport ctrl (output resetN, cke, csN, rasN, casN, weN, odt, ba, addr, dm, dq);
  modport dev (input resetN, cke, csN, rasN, casN, weN, odt, ba, addr, dm, dq);
endinterface

/* verilog/dps_pkg.sv */
// Shared constants, codes and state types for the DDR3 power-state controller and device ends.
package dps_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CLK_NS = 4;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int BANKS = 8;
  localparam int CNT_W = 20;
  localparam int TMR_W = 10;
  localparam int APB_AW = 8;

  localparam int RESET_HOLD_US = 200;
  localparam int CKE_LEAD_NS = 10;
  localparam int INIT_WAIT_US = 500;
  localparam int CLK_STABLE_NS = 10;
  localparam int CLK_STABLE_TCK = 5;
  localparam int XPR_MIN_TCK = 5;
  localparam int SR_WR_NCK = 512;
  localparam int CKE_LEAD_CYC = (CKE_LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLK_STABLE_CYC = ((CLK_STABLE_NS + CLK_NS - 1) / CLK_NS > CLK_STABLE_TCK) ?
                                  (CLK_STABLE_NS + CLK_NS - 1) / CLK_NS : CLK_STABLE_TCK;
  localparam int TCKE_CYC = 3;
  localparam int TXS_CYC = 100;
  localparam int TXP_CYC = 3;
  localparam int TXSDLL_CYC = 512;
  localparam int TMRD_CYC = 4;
  localparam int TMOD_CYC = 12;
  localparam int TDLLK_CYC = 512;
  localparam int TZQINIT_CYC = 512;
  localparam int BURST_CYC = 4;
  localparam int TXPR_CYC = (TXS_CYC > XPR_MIN_TCK) ? TXS_CYC : XPR_MIN_TCK;
  localparam int TINIT_CYC = (TDLLK_CYC > TZQINIT_CYC) ? TDLLK_CYC : TZQINIT_CYC;

  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
  localparam logic [TMR_W-1:0] TMR_ONE = 10'h001;
  localparam logic [TMR_W-1:0] TMR_ZERO = 10'h000;

  // Command code is {cs_n, ras_n, cas_n, we_n}; any code with cs_n high is a deselect.
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'h8;

  localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
  localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
  localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
  localparam logic [BA_W-1:0] BA_MR3 = 3'h3;
  localparam int MR1_DLL_BIT = 0;
  localparam int MR0_DLLRST_BIT = 8;
  localparam int AP_BIT = 10;

  localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_CMD = 8'h04;
  localparam logic [APB_AW-1:0] OFF_WDATA = 8'h08;
  localparam logic [APB_AW-1:0] OFF_MR01 = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_MR23 = 8'h10;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h14;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_ODT_BIT = 1;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BA_LSB = 4;
  localparam int CMD_ADDR_LSB = 16;
  localparam int WD_MASK_LSB = 16;
  localparam int MR_LO_LSB = 0;
  localparam int MR_HI_LSB = 16;
  localparam int ST_DONE_BIT = 4;
  localparam int ST_PEND_BIT = 5;
  localparam int ST_CKE_BIT = 6;
  localparam int ST_RST_BIT = 7;

  localparam logic [3:0] OP_ACT = 4'h0;
  localparam logic [3:0] OP_RD = 4'h1;
  localparam logic [3:0] OP_WR = 4'h2;
  localparam logic [3:0] OP_PRE = 4'h3;
  localparam logic [3:0] OP_REF = 4'h4;
  localparam logic [3:0] OP_PDE = 4'h5;
  localparam logic [3:0] OP_PDX = 4'h6;
  localparam logic [3:0] OP_SRE = 4'h7;
  localparam logic [3:0] OP_SRX = 4'h8;

  typedef enum logic [2:0] {
    D_RESET = 3'h0, D_INIT = 3'h1, D_NORM = 3'h2, D_APD = 3'h3, D_PPD = 3'h4, D_SREF = 3'h5
  } dps_dev_state_t;

  typedef enum logic [3:0] {
    C_OFF = 4'h0, C_RSTHOLD = 4'h1, C_CKELEAD = 4'h2, C_WAIT = 4'h3, C_NOP = 4'h4,
    C_XPR = 4'h5, C_MRS = 4'h6, C_MOD = 4'h7, C_ZQ = 4'h8, C_READY = 4'h9,
    C_PD = 4'hA, C_SREF = 4'hB
  } dps_ctrl_state_t;
endpackage
